//--- byte_reg.v
// One 8-bit register with synchronous reset and per-bit write enables.
// Assumes the decoder supplies the merged next value and bit enables.
`timescale 1ns/1ps
`default_nettype none

module byte_reg #(
    parameter [7:0] RESET_VALUE = 8'h00
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Write port
    input wire [7:0] bit_we,
    input wire [7:0] wdata,
    // Stored value
    output reg [7:0] q
);

    integer i;

    always @(posedge clk) begin
        if (!rst_n) begin
            q <= RESET_VALUE;
        end else begin
            for (i = 0; i < 8; i = i + 1) begin
                if (bit_we[i]) begin
                    q[i] <= wdata[i];
                end
            end
        end
    end

endmodule

`default_nettype wire

//--- cpu_core_model.sv
// Model of the CPU core issuing one I/O or data-space operation at a time.
// Assumes the decoder answers on the taking edge, before the next falling edge.
`timescale 1ns/1ps
`default_nettype none
`include "io_space_defines.vh"
module cpu_core_model (
    // Clock
    input wire logic clk,
    // Operation
    output var logic op_valid,
    output var logic [2:0] op_code,
    output var logic [7:0] op_addr,
    output var logic [2:0] op_bit,
    output var logic [7:0] op_wdata,
    // Answers
    input wire logic [7:0] rdata,
    input wire logic rdata_valid,
    input wire logic bit_value,
    input wire logic bit_valid
);
    initial begin
        op_valid = 1'b0;
        op_code = `OP_NONE;
        op_addr = 8'h00;
        op_bit = 3'h0;
        op_wdata = 8'h00;
    end
    task automatic run(input logic [2:0] c, input logic [7:0] a, input logic [2:0] b,
                       input logic [7:0] d, output logic [7:0] r);
        if ((c == `OP_OUT || c == `OP_STORE) && a == 8'h00) c = `OP_NONE;
        @(negedge clk);
        op_valid = 1'b1;
        op_code = c;
        op_addr = a;
        op_bit = b;
        op_wdata = d & 8'hFF;
        @(negedge clk);
        op_valid = 1'b0;
        op_wdata = ~op_wdata;
        r = bit_valid ? {7'h00, bit_value} : (rdata_valid ? rdata : 8'hXX);
    endtask
endmodule
`default_nettype wire

//--- io_space_decode_scratch_regs.v
// I/O space decoder with three scratch registers, one flag register and
// one extended control register.
// Assumes one operation per cycle from the CPU core on clk.
`timescale 1ns/1ps
`default_nettype none
`include "io_space_defines.vh"

// What this block does
// RL1: Registers at I/O addresses up to 0x1F can be changed one bit at a time by set and clear.
// RL2: A bit test on the low range reports whether the selected bit is set or clear.
// RL3: Short in and out transfers reach I/O addresses 0x00 to 0x3F.
// RL4: Data-space access to the low I/O registers uses their I/O address plus 0x20.
// RL5: Every I/O location can be loaded and stored through data space.
// RL6: Extended registers at data 0x60 to 0xFF are reachable only by loads and stores.
// RL7: Some status flags clear when written with one and keep their value when written with zero.
// RL8: A bit set or clear writes only the addressed bit and clears no other flag.
// RL9: Software writes zero to reserved bits it touches.
// RL10: Software never writes reserved, unassigned I/O addresses.
// RL11: General-purpose scratch registers in the low range hold any software value.
// RL12: Each scratch register is 8 bits, fully read/write, and resets to zero.
// RL13: Unassigned addresses read as zero and ignore writes.
module io_space_decode_scratch_regs (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // CPU operation
    input wire op_valid,
    input wire [2:0] op_code,
    input wire [7:0] op_addr,
    input wire [2:0] op_bit,
    input wire [7:0] op_wdata,
    // Hardware flag events
    input wire [7:0] flag_event,
    // Answers
    output reg [7:0] rdata,
    output reg rdata_valid,
    output reg bit_value,
    output reg bit_valid,
    // Register contents
    output reg [7:0] scratch0_out,
    output reg [7:0] scratch1_out,
    output reg [7:0] scratch2_out,
    output reg [7:0] flag_out,
    output reg [7:0] ext_ctrl_out
);

    // ****************************************
    // Address resolution
    // ****************************************
    wire is_short;
    wire is_bitop;
    wire is_data;
    wire io_hit;
    wire ext_hit;
    wire [5:0] io_addr;
    wire [7:0] data_minus;

    assign is_short = (op_code == `OP_IN) || (op_code == `OP_OUT);
    assign is_bitop = (op_code == `OP_SET_BIT) || (op_code == `OP_CLR_BIT) ||
                      (op_code == `OP_TEST_BIT);
    assign is_data = (op_code == `OP_LOAD) || (op_code == `OP_STORE);
    assign data_minus = op_addr - `IO_DATA_OFFSET;
    // Short transfers use the 6-bit I/O address directly.
    assign io_hit = op_valid && (
        (is_short && (op_addr <= {2'b00, `IO_SHORT_LAST})) ||  // see RL3
        (is_bitop && (op_addr <= {2'b00, `IO_BIT_LAST})) ||  // see RL1
        (is_data && (op_addr >= `IO_DATA_FIRST) && (op_addr <= `IO_DATA_LAST)));  // see RL4
    // Extended space only answers data-space operations.
    assign ext_hit = op_valid && is_data && (op_addr >= `EXT_DATA_FIRST);  // see RL6
    assign io_addr = is_data ? data_minus[5:0] : op_addr[5:0];  // see RL4

    wire is_write;
    wire is_read;
    assign is_write = (op_code == `OP_OUT) || (op_code == `OP_STORE);  // see RL5
    assign is_read = (op_code == `OP_IN) || (op_code == `OP_LOAD);  // see RL5

    // ****************************************
    // Bit masks
    // ****************************************
    wire [7:0] bit_mask;
    assign bit_mask = 8'h01 << op_bit;

    // ****************************************
    // Scratch registers
    // ****************************************
    wire [7:0] sc0_q;
    wire [7:0] sc1_q;
    wire [7:0] sc2_q;
    reg [7:0] sc0_we;
    reg [7:0] sc1_we;
    reg [7:0] sc2_we;
    reg [7:0] sc_wdata;

    always @* begin
        sc0_we = 8'h00;
        sc1_we = 8'h00;
        sc2_we = 8'h00;
        sc_wdata = op_wdata;
        if (io_hit && (op_code == `OP_SET_BIT)) begin
            sc_wdata = 8'hFF;
        end
        if (io_hit && (op_code == `OP_CLR_BIT)) begin
            sc_wdata = 8'h00;
        end
        if (io_hit) begin
            if (io_addr == `SCRATCH0_ADDR) begin
                if (is_write) begin
                    sc0_we = 8'hFF;  // see RL11
                end else if ((op_code == `OP_SET_BIT) || (op_code == `OP_CLR_BIT)) begin
                    sc0_we = bit_mask;  // see RL1
                end
            end
            if (io_addr == `SCRATCH1_ADDR) begin
                if (is_write) begin
                    sc1_we = 8'hFF;  // see RL11
                end else if ((op_code == `OP_SET_BIT) || (op_code == `OP_CLR_BIT)) begin
                    sc1_we = bit_mask;  // see RL1
                end
            end
            if (io_addr == `SCRATCH2_ADDR) begin
                if (is_write) begin
                    sc2_we = 8'hFF;  // see RL11
                end else if ((op_code == `OP_SET_BIT) || (op_code == `OP_CLR_BIT)) begin
                    sc2_we = bit_mask;  // see RL1
                end
            end
        end
    end

    // Scratch cells reset to zero and store all eight bits.
    byte_reg #(.RESET_VALUE(`SCRATCH_RESET)) u_scratch0 (  // see RL12
        .clk(clk),
        .rst_n(rst_n),
        .bit_we(sc0_we),
        .wdata(sc_wdata),
        .q(sc0_q)
    );

    byte_reg #(.RESET_VALUE(`SCRATCH_RESET)) u_scratch1 (  // see RL12
        .clk(clk),
        .rst_n(rst_n),
        .bit_we(sc1_we),
        .wdata(sc_wdata),
        .q(sc1_q)
    );

    byte_reg #(.RESET_VALUE(`SCRATCH_RESET)) u_scratch2 (  // see RL12
        .clk(clk),
        .rst_n(rst_n),
        .bit_we(sc2_we),
        .wdata(sc_wdata),
        .q(sc2_q)
    );

    // ****************************************
    // Write-one-to-clear flag register
    // ****************************************
    reg [7:0] flags;
    reg [7:0] flag_clear;
    reg [7:0] next_flags;

    always @* begin
        flag_clear = 8'h00;
        if (io_hit && (io_addr == `FLAG_ADDR)) begin
            if (is_write) begin
                flag_clear = op_wdata;  // see RL7
            end else if (op_code == `OP_SET_BIT) begin
                flag_clear = bit_mask;  // see RL8
            end
        end
        // A hardware event wins over a clear in the same cycle.
        next_flags = (flags & ~flag_clear) | flag_event;
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            flags <= `FLAG_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    // ****************************************
    // Extended control register
    // ****************************************
    reg [7:0] ext_ctrl;

    always @(posedge clk) begin
        if (!rst_n) begin
            ext_ctrl <= `EXT_RESET;
        end else if (ext_hit && (op_code == `OP_STORE) &&
                     (op_addr == `EXT_CTRL_ADDR)) begin
            ext_ctrl <= op_wdata;  // see RL6
        end
    end

    // ****************************************
    // Read multiplexer
    // ****************************************
    reg [7:0] io_rd;
    reg [7:0] next_rdata;

    always @* begin
        io_rd = `ZERO_BYTE;
        case (io_addr)
            `SCRATCH0_ADDR: io_rd = sc0_q;
            `SCRATCH1_ADDR: io_rd = sc1_q;
            `SCRATCH2_ADDR: io_rd = sc2_q;
            `FLAG_ADDR: io_rd = flags;
            default: io_rd = `ZERO_BYTE;  // see RL13
        endcase
        next_rdata = `ZERO_BYTE;
        if (io_hit) begin
            next_rdata = io_rd;
        end else if (ext_hit && (op_addr == `EXT_CTRL_ADDR)) begin
            next_rdata = ext_ctrl;
        end
    end

    // ****************************************
    // Answer registers
    // ****************************************
    always @(posedge clk) begin
        if (!rst_n) begin
            rdata <= `ZERO_BYTE;
            rdata_valid <= 1'b0;
            bit_value <= 1'b0;
            bit_valid <= 1'b0;
        end else begin
            rdata_valid <= op_valid && is_read;
            if (op_valid && is_read) begin
                rdata <= next_rdata;  // see RL13
            end
            bit_valid <= op_valid && (op_code == `OP_TEST_BIT);
            if (op_valid && (op_code == `OP_TEST_BIT)) begin
                bit_value <= io_hit ? io_rd[op_bit] : 1'b0;  // see RL2
            end
        end
    end

    // ****************************************
    // Register content outputs
    // ****************************************
    always @(posedge clk) begin
        if (!rst_n) begin
            scratch0_out <= `SCRATCH_RESET;
            scratch1_out <= `SCRATCH_RESET;
            scratch2_out <= `SCRATCH_RESET;
            flag_out <= `FLAG_RESET;
            ext_ctrl_out <= `EXT_RESET;
        end else begin
            scratch0_out <= sc0_q;
            scratch1_out <= sc1_q;
            scratch2_out <= sc2_q;
            flag_out <= flags;
            ext_ctrl_out <= ext_ctrl;
        end
    end

endmodule

`default_nettype wire

//--- io_space_decode_scratch_regs_properties.sv
// Port checker for the I/O space decoder and scratch bank.
// Assumes one operation per cycle and a quiet cycle between writes.
`timescale 1ns/1ps
`default_nettype none
`include "io_space_defines.vh"
module io_space_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Operation
    input wire logic op_valid,
    input wire logic [2:0] op_code,
    input wire logic [7:0] op_addr,
    input wire logic [2:0] op_bit,
    input wire logic [7:0] op_wdata,
    // Answers and contents
    input wire logic [7:0] rdata,
    input wire logic rdata_valid,
    input wire logic bit_valid,
    input wire logic [7:0] scratch0_out,
    input wire logic [7:0] scratch1_out,
    input wire logic [7:0] scratch2_out,
    input wire logic [7:0] flag_out,
    input wire logic [7:0] ext_ctrl_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic read_op;
    wire logic test_op;
    assign read_op = op_valid && (op_code == `OP_IN || op_code == `OP_LOAD);
    assign test_op = op_valid && (op_code == `OP_TEST_BIT);
    property p_in_answer;
        op_valid && op_code == `OP_IN && op_addr <= 8'h3F |=> rdata_valid ##1
            (rdata_valid == $past(read_op));
    endproperty
    a_in_answer: assert property (p_in_answer) else $error("No read answer.");
    property p_test_answer;
        test_op |=> bit_valid ##1 (bit_valid == $past(test_op));
    endproperty
    a_test_answer: assert property (p_test_answer) else $error("No test answer.");
    property p_unmapped;
        op_valid && op_code == `OP_IN && op_addr == 8'h00 |=> rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero.");
    property p_scratch_out;
        op_valid && op_code == `OP_OUT && op_addr == 8'h1C |-> ##2 scratch0_out == $past(op_wdata, 2);
    endproperty
    a_scratch_out: assert property (p_scratch_out) else $error("Scratch write lost.");
    property p_data_view;
        op_valid && op_code == `OP_STORE && op_addr == 8'h3D |-> ##2 scratch1_out == $past(op_wdata, 2);
    endproperty
    a_data_view: assert property (p_data_view) else $error("Data view store lost.");
    property p_set_bit;
        op_valid && op_code == `OP_SET_BIT && op_addr == 8'h1E
            |-> ##2 scratch2_out == ($past(scratch2_out) | (8'h01 << $past(op_bit, 2)));
    endproperty
    a_set_bit: assert property (p_set_bit) else $error("Bit set wrong.");
    property p_flag_clear;
        |($past(flag_out) & ~flag_out) |-> $past(op_valid, 2) && ($past(op_code, 2) == `OP_OUT
            || $past(op_code, 2) == `OP_STORE || $past(op_code, 2) == `OP_SET_BIT);
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("Flag cleared alone.");
    property p_ext_short;
        op_valid && op_code == `OP_OUT && op_addr == `EXT_CTRL_ADDR |-> ##2 $stable(ext_ctrl_out);
    endproperty
    a_ext_short: assert property (p_ext_short) else $error("Short write hit ext.");
endmodule
bind io_space_decode_scratch_regs io_space_checker i_chk (.clk(clk), .rst_n(rst_n),
    .op_valid(op_valid), .op_code(op_code), .op_addr(op_addr), .op_bit(op_bit),
    .op_wdata(op_wdata), .rdata(rdata), .rdata_valid(rdata_valid), .bit_valid(bit_valid),
    .scratch0_out(scratch0_out), .scratch1_out(scratch1_out), .scratch2_out(scratch2_out),
    .flag_out(flag_out), .ext_ctrl_out(ext_ctrl_out));
`default_nettype wire

//--- io_space_defines.vh
// Constants for the peripheral I/O space decoder and scratch bank.
// Assumes inclusion by bare name from design files in the same folder.
`ifndef IO_SPACE_DEFINES_VH
`define IO_SPACE_DEFINES_VH

// ****************************************
// Address views
// ****************************************
`define IO_BIT_LAST 6'h1F
`define IO_SHORT_LAST 6'h3F
`define IO_DATA_OFFSET 8'h20
`define IO_DATA_FIRST 8'h20
`define IO_DATA_LAST 8'h5F
`define EXT_DATA_FIRST 8'h60
`define EXT_DATA_LAST 8'hFF

// ****************************************
// Register placement and reset
// ****************************************
`define SCRATCH0_ADDR 6'h1C
`define SCRATCH1_ADDR 6'h1D
`define SCRATCH2_ADDR 6'h1E
`define FLAG_ADDR 6'h16
`define EXT_CTRL_ADDR 8'h80
`define SCRATCH_RESET 8'h00
`define FLAG_RESET 8'h00
`define EXT_RESET 8'h00
`define ZERO_BYTE 8'h00

// ****************************************
// Operation codes
// ****************************************
`define OP_NONE 3'h0
`define OP_IN 3'h1
`define OP_OUT 3'h2
`define OP_LOAD 3'h3
`define OP_STORE 3'h4
`define OP_SET_BIT 3'h5
`define OP_CLR_BIT 3'h6
`define OP_TEST_BIT 3'h7

`endif

//--- tb_io_space_decode_scratch_regs.sv
// Self-checking bench for the I/O space decoder and scratch bank.
// Assumes the design, its checker and the CPU core model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "io_space_defines.vh"
module tb_io_space_decode_scratch_regs;
    logic clk, rst_n, op_valid, rdata_valid, bit_value, bit_valid;
    logic [2:0] op_code, op_bit;
    logic [7:0] op_addr, op_wdata, flag_event, rdata, s0, s1, s2, fl, ext, r, i;
    int mismatches, checked;
    io_space_decode_scratch_regs i_dut (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
        .op_code(op_code), .op_addr(op_addr), .op_bit(op_bit), .op_wdata(op_wdata),
        .flag_event(flag_event), .rdata(rdata), .rdata_valid(rdata_valid),
        .bit_value(bit_value), .bit_valid(bit_valid), .scratch0_out(s0), .scratch1_out(s1),
        .scratch2_out(s2), .flag_out(fl), .ext_ctrl_out(ext));
    cpu_core_model i_cpu (.clk(clk), .op_valid(op_valid), .op_code(op_code), .op_addr(op_addr),
        .op_bit(op_bit), .op_wdata(op_wdata), .rdata(rdata), .rdata_valid(rdata_valid),
        .bit_value(bit_value), .bit_valid(bit_valid));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task op(input logic [2:0] c, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d);
        i_cpu.run(c, a, b, d, r);
    endtask
    task summarize;
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #20000;
        mismatches++;
        summarize;
    end
    initial begin
        rst_n = 1'b0;
        flag_event = 8'h00;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check(s0 | s1 | s2, 8'h00);
        $display("Reset test done.");
        for (i = 8'h00; i < 8'h03; i++) begin
            op(`OP_OUT, 8'h1C + i, 3'h0, 8'hA0 + i);
            op(`OP_IN, 8'h1C + i, 3'h0, 8'h00);
            check(r, 8'hA0 + i);
            op(`OP_LOAD, 8'h3C + i, 3'h0, 8'h00);
            check(r, 8'hA0 + i);
            op(`OP_STORE, 8'h3C + i, 3'h0, 8'h50 + i);
            op(`OP_IN, 8'h1C + i, 3'h0, 8'h00);
            check(r, 8'h50 + i);
        end
        op(`OP_LOAD, 8'h1C, 3'h0, 8'h00);
        check(r, 8'h00);
        op(`OP_IN, 8'h00, 3'h0, 8'h00);
        check(r, 8'h00);
        $display("Scratch access test done.");
        op(`OP_CLR_BIT, 8'h1D, 3'h0, 8'h00);
        op(`OP_SET_BIT, 8'h1D, 3'h7, 8'h00);
        op(`OP_SET_BIT, 8'h1E, 3'h0, 8'h00);
        op(`OP_IN, 8'h1D, 3'h0, 8'h00);
        check(r, 8'hD0);
        op(`OP_IN, 8'h1E, 3'h0, 8'h00);
        check(r, 8'h53);
        op(`OP_TEST_BIT, 8'h1D, 3'h7, 8'h00);
        check(r, 8'h01);
        op(`OP_TEST_BIT, 8'h1D, 3'h0, 8'h00);
        check(r, 8'h00);
        op(`OP_SET_BIT, 8'h3C, 3'h0, 8'h00);
        op(`OP_IN, 8'h1C, 3'h0, 8'h00);
        check(r, 8'h50);
        check(s1, 8'hD0);
        $display("Bit operation test done.");
        op(`OP_STORE, 8'h80, 3'h0, 8'h3C);
        op(`OP_LOAD, 8'h80, 3'h0, 8'h00);
        check(r, 8'h3C);
        op(`OP_OUT, 8'h80, 3'h0, 8'hFF);
        op(`OP_IN, 8'h80, 3'h0, 8'h00);
        check(r, 8'h00);
        op(`OP_LOAD, 8'h80, 3'h0, 8'h00);
        check(r, 8'h3C);
        check(ext, 8'h3C);
        $display("Extended space test done.");
        @(negedge clk) flag_event = 8'h0F;
        @(negedge clk) flag_event = 8'h00;
        op(`OP_SET_BIT, 8'h16, 3'h1, 8'h00);
        op(`OP_IN, 8'h16, 3'h0, 8'h00);
        check(r, 8'h0D);
        op(`OP_OUT, 8'h16, 3'h0, 8'h04);
        op(`OP_OUT, 8'h16, 3'h0, 8'h00);
        op(`OP_CLR_BIT, 8'h16, 3'h3, 8'h00);
        op(`OP_IN, 8'h16, 3'h0, 8'h00);
        check(r, 8'h09);
        op(`OP_STORE, 8'h36, 3'h0, 8'h01);
        op(`OP_LOAD, 8'h36, 3'h0, 8'h00);
        check(r, 8'h08);
        check(fl, 8'h08);
        $display("Flag test done.");
        @(negedge clk) rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check(s0 | s1 | s2, 8'h00);
        check(fl, 8'h00);
        check(ext, 8'h00);
        op(`OP_IN, 8'h1C, 3'h0, 8'h00);
        check(r, 8'h00);
        $display("Mid-run reset test done.");
        summarize;
    end
endmodule
`default_nettype wire
